// [loop_ctrl_pkg.sv]
// package for the loop window and duration control block
// assumes a 100 MHz system clock and APB register access
package loop_ctrl_pkg;

  localparam int          CLK_HZ          = 100_000_000;
  localparam int          SAMPLE_HZ       = 48_000;
  localparam int          MEM_SECONDS     = 174;                 // 2 min 54 s
  localparam int          MEM_DEPTH       = SAMPLE_HZ * MEM_SECONDS;
  localparam int          ADDR_W          = 24;
  localparam int          CLEAR_HOLD_S    = 2;
  localparam int          CLEAR_HOLD_CYC  = CLEAR_HOLD_S * CLK_HZ;
  localparam int          KNOB_W          = 12;
  localparam int          CV_W            = 12;
  localparam int          VOLT_STEP       = 683;                 // cv codes per volt
  localparam int          MAX_OCT         = 5;
  localparam int          BAR_BEATS       = 4;
  localparam int          RANGE_BARS      = 16;

  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_KNOBS       = 8'h04;
  localparam logic [7:0]  OFF_CV          = 8'h08;
  localparam logic [7:0]  OFF_BEAT        = 8'h0c;
  localparam logic [7:0]  OFF_STAT        = 8'h10;
  localparam logic [7:0]  OFF_START       = 8'h14;
  localparam logic [7:0]  OFF_END         = 8'h18;
  localparam logic [7:0]  OFF_PERIOD      = 8'h1c;

  // ctrl field positions
  localparam int          CB_FREEZE_BTN   = 0;
  localparam int          CB_FLIP_BTN     = 1;
  localparam int          CB_FREEZE_TGL   = 2;
  localparam int          CB_RANGE_UP     = 3;
  localparam int          CB_CHAN         = 4;
  localparam int          CB_WET_VALID    = 5;

  localparam logic [31:0] RST_BEAT        = 32'h0000_bb80;      // plain default beat

  typedef enum logic [1:0] {ST_RUN, ST_FROZEN, ST_CLEARING} mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] start_ptr;
    logic [ADDR_W-1:0] end_ptr;
    logic [ADDR_W-1:0] wr_ptr;
    logic [ADDR_W-1:0] rd_ptr;
    mode_t             mode;
    logic              cv_window;
    logic              continuous;
    logic [31:0]       clr_cnt;
    logic [ADDR_W-1:0] clr_addr;
  } chan_t;

  typedef struct packed {
    logic             freeze_btn;
    logic             flip_btn;
    logic             range_up;
    logic [KNOB_W-1:0] regen_knob;
    logic [KNOB_W-1:0] dur_knob;
    logic [CV_W-1:0]  regen_cv;
    logic [CV_W-1:0]  dur_cv;
  } panel_t;

endpackage : loop_ctrl_pkg

// [loop_ctrl.sv]
// two channel loop window, duration mode, buffer clear and circular memory control
// assumes APB master on I_SYS_CLK, panel values written by firmware over APB
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module loop_ctrl #(
  parameter int DEPTH      = loop_ctrl_pkg::MEM_DEPTH,
  parameter int CLEAR_CYC  = loop_ctrl_pkg::CLEAR_HOLD_CYC
) (
  input  wire logic                             I_SYS_CLK,
  input  wire logic                             I_RESET,
  input  wire logic                             PSEL,
  input  wire logic                             PENABLE,
  input  wire logic                             PWRITE,
  input  wire logic [7:0]                       PADDR,
  input  wire logic [31:0]                      PWDATA,
  output logic      [31:0]                      PRDATA,
  output logic                                  PREADY,
  output logic                                  PSLVERR,
  output logic      [1:0]                       O_MUTE,
  output logic      [1:0]                       O_LED_FLASH,
  output logic      [1:0]                       O_REC_EN,
  output logic      [1:0]                       O_REGEN_FULL,
  output logic      [2*loop_ctrl_pkg::ADDR_W-1:0] O_WR_ADDR,
  output logic      [2*loop_ctrl_pkg::ADDR_W-1:0] O_RD_ADDR
);
  localparam int AW = loop_ctrl_pkg::ADDR_W;
  localparam int KW = loop_ctrl_pkg::KNOB_W;
  localparam logic [AW-1:0] DEPTH_A = AW'(DEPTH);
  localparam logic [31:0]   CLR_LAST = 32'(CLEAR_CYC - 1);

  typedef struct packed {
    loop_ctrl_pkg::chan_t [1:0]  ch;
    loop_ctrl_pkg::panel_t [1:0] pan;
    loop_ctrl_pkg::panel_t [1:0] pan_prev;
    logic [1:0]                  tgl;
    logic [31:0]                 beat;
    logic [1:0][31:0]            period;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    logic [1:0]                  flash;
    logic [22:0]                 flash_div;
  } state_t;

  state_t s_q;
  state_t s_d;

  // wrap an offset into [0, DEPTH)
  function automatic logic [AW-1:0] wrap_add(input logic [AW-1:0] p, input logic signed [AW+1:0] off);
    logic signed [AW+2:0] v;
    v = $signed({3'b000, p}) + (AW+3)'(off);
    if (v < 0)
      v = v + $signed({3'b000, DEPTH_A});
    else if (v >= $signed({3'b000, DEPTH_A}))
      v = v - $signed({3'b000, DEPTH_A});
    return v[AW-1:0];
  endfunction : wrap_add

  // quantize a knob or cv code into 31 steps: 1/16..1 then 2..16 beats, result in 1/16 beats
  function automatic logic [31:0] snap_sixteenths(input logic [KW:0] code);
    logic [4:0] idx;
    idx = 5'((32'(code) * 31) >> (KW + 1));
    if (idx < 5'd16)
      return 32'(idx) + 32'd1;
    return (32'(idx) - 32'd14) * 32'd16;
  endfunction : snap_sixteenths

  logic apb_acc;
  assign apb_acc = PSEL && PENABLE && !s_q.pready;

  always_comb begin
    logic signed [AW+1:0] shift;
    logic signed [KW:0]   travel;
    logic [AW-1:0]        len;
    logic [KW:0]          sum;
    logic [2:0]           volts;
    logic [31:0]          p;
    logic                 regen_moved;
    logic                 dur_moved;
    logic                 hold_both;
    shift = '0;
    travel = '0;
    len = '0;
    sum = '0;
    volts = '0;
    p = '0;
    regen_moved = 1'b0;
    dur_moved = 1'b0;
    hold_both = 1'b0;
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.tgl = 2'b00;
    s_d.flash_div = s_q.flash_div + 23'd1;

    if (apb_acc) begin
      s_d.pready = 1'b1;
      if (PWRITE) begin
        case (PADDR)
          loop_ctrl_pkg::OFF_CTRL: begin
            s_d.pan[PWDATA[loop_ctrl_pkg::CB_CHAN]].freeze_btn = PWDATA[loop_ctrl_pkg::CB_FREEZE_BTN];
            s_d.pan[PWDATA[loop_ctrl_pkg::CB_CHAN]].flip_btn   = PWDATA[loop_ctrl_pkg::CB_FLIP_BTN];
            s_d.pan[PWDATA[loop_ctrl_pkg::CB_CHAN]].range_up   = PWDATA[loop_ctrl_pkg::CB_RANGE_UP];
            s_d.tgl[PWDATA[loop_ctrl_pkg::CB_CHAN]]           = PWDATA[loop_ctrl_pkg::CB_FREEZE_TGL];
          end
          loop_ctrl_pkg::OFF_KNOBS: begin
            s_d.pan[PWDATA[31]].regen_knob = PWDATA[KW-1:0];
            s_d.pan[PWDATA[31]].dur_knob   = PWDATA[16+KW-1:16];
          end
          loop_ctrl_pkg::OFF_CV: begin
            s_d.pan[PWDATA[31]].regen_cv = PWDATA[KW-1:0];
            s_d.pan[PWDATA[31]].dur_cv   = PWDATA[16+KW-1:16];
          end
          loop_ctrl_pkg::OFF_BEAT: s_d.beat = PWDATA;
          default: s_d.pslverr = (PADDR[7:5] != 3'b000);
        endcase
      end else begin
        case (PADDR)
          loop_ctrl_pkg::OFF_BEAT:   s_d.prdata = s_q.beat;
          loop_ctrl_pkg::OFF_STAT:   s_d.prdata = {24'h0, s_q.ch[1].continuous, s_q.ch[1].cv_window,
                                                   2'(s_q.ch[1].mode), s_q.ch[0].continuous,
                                                   s_q.ch[0].cv_window, 2'(s_q.ch[0].mode)};
          loop_ctrl_pkg::OFF_START:  s_d.prdata = 32'(s_q.ch[PADDR[0]].start_ptr);
          loop_ctrl_pkg::OFF_END:    s_d.prdata = 32'(s_q.ch[PADDR[0]].end_ptr);
          loop_ctrl_pkg::OFF_PERIOD: s_d.prdata = s_q.period[0];
          default: begin
            s_d.prdata = 32'h0;
            s_d.pslverr = (PADDR > loop_ctrl_pkg::OFF_PERIOD);
          end
        endcase
      end
    end

    s_d.pan_prev = s_q.pan;

    for (int c = 0; c < 2; c++) begin
      regen_moved = s_q.pan[c].regen_knob != s_q.pan_prev[c].regen_knob;
      dur_moved   = s_q.pan[c].dur_knob != s_q.pan_prev[c].dur_knob;
      hold_both   = s_q.pan[c].freeze_btn && s_q.pan[c].flip_btn;

      // duration mode switching
      if (dur_moved)
        s_d.ch[c].continuous = s_q.pan[c].freeze_btn;

      // loop period in samples from shared beat
      sum = (KW+1)'(s_q.pan[c].dur_knob);
      if (s_q.ch[c].continuous) begin
        p = 32'((64'(s_q.beat) * (64'(s_q.pan[c].dur_knob) + 64'd1) * 64'd16) >> KW);
        volts = 3'(32'(s_q.pan[c].dur_cv) / loop_ctrl_pkg::VOLT_STEP);
        if (volts > 3'(loop_ctrl_pkg::MAX_OCT))
          volts = 3'(loop_ctrl_pkg::MAX_OCT);
        p = p >> volts;
      end else begin
        sum = (KW+1)'(s_q.pan[c].dur_knob) + (KW+1)'(s_q.pan[c].dur_cv);
        p = 32'((64'(s_q.beat) * 64'(snap_sixteenths(sum))) >> 4);
      end
      if (s_q.pan[c].range_up)
        p = p + s_q.beat * 32'(loop_ctrl_pkg::RANGE_BARS * loop_ctrl_pkg::BAR_BEATS);
      if (p == 32'h0)
        p = 32'h1;
      if (p > 32'(DEPTH))
        p = 32'(DEPTH);
      s_d.period[c] = p;
      len = AW'(p);

      // cv ownership of the window
      if (regen_moved)
        s_d.ch[c].cv_window = s_q.pan[c].freeze_btn;

      case (s_q.ch[c].mode)
        loop_ctrl_pkg::ST_RUN: begin
          s_d.ch[c].wr_ptr = wrap_add(s_q.ch[c].wr_ptr, (AW+2)'(1));
          s_d.ch[c].rd_ptr = wrap_add(s_q.ch[c].wr_ptr, -$signed({2'b00, len}) + (AW+2)'(1));
          if (s_q.tgl[c]) begin
            s_d.ch[c].mode = loop_ctrl_pkg::ST_FROZEN;
            s_d.ch[c].start_ptr = s_q.ch[c].rd_ptr;
            s_d.ch[c].end_ptr   = s_q.ch[c].wr_ptr;
          end
        end
        loop_ctrl_pkg::ST_FROZEN: begin
          if (s_q.tgl[c])
            s_d.ch[c].mode = loop_ctrl_pkg::ST_RUN;
          // knob with button held, or cv once it owns the window
          if (regen_moved && s_q.pan[c].freeze_btn)
            travel = $signed({1'b0, s_q.pan[c].regen_knob}) - $signed({1'b0, s_q.pan_prev[c].regen_knob});
          else if (s_q.ch[c].cv_window)
            travel = $signed({1'b0, s_q.pan[c].regen_cv}) - $signed({1'b0, s_q.pan_prev[c].regen_cv});
          else
            travel = '0;
          // a step is at most one loop, and a loop never exceeds the memory depth
          shift = (AW+2)'((64'(signed'(travel)) * 64'(len)) >>> KW);
          if (travel != 0) begin
            s_d.ch[c].start_ptr = wrap_add(s_q.ch[c].start_ptr, shift);
            s_d.ch[c].end_ptr   = wrap_add(s_q.ch[c].end_ptr, shift);
          end
          if (s_q.ch[c].rd_ptr == s_q.ch[c].end_ptr)
            s_d.ch[c].rd_ptr = s_q.ch[c].start_ptr;
          else
            s_d.ch[c].rd_ptr = wrap_add(s_q.ch[c].rd_ptr, (AW+2)'(1));
        end
        loop_ctrl_pkg::ST_CLEARING: begin
          s_d.ch[c].clr_addr = wrap_add(s_q.ch[c].clr_addr, (AW+2)'(1));
          if (!hold_both && s_q.ch[c].clr_addr == DEPTH_A - AW'(1)) begin
            s_d.ch[c].mode = loop_ctrl_pkg::ST_RUN;
            s_d.ch[c].clr_cnt = '0;
          end
        end
        default: s_d.ch[c].mode = loop_ctrl_pkg::ST_RUN;
      endcase

      // two second hold of both buttons starts a clear of this channel
      if (s_q.ch[c].mode != loop_ctrl_pkg::ST_CLEARING) begin
        if (!hold_both)
          s_d.ch[c].clr_cnt = '0;
        else if (s_q.ch[c].clr_cnt == CLR_LAST) begin
          s_d.ch[c].mode = loop_ctrl_pkg::ST_CLEARING;
          s_d.ch[c].clr_addr = '0;
        end else
          s_d.ch[c].clr_cnt = s_q.ch[c].clr_cnt + 32'd1;
      end
      s_d.flash[c] = (s_d.ch[c].mode == loop_ctrl_pkg::ST_CLEARING) && s_q.flash_div[22];
    end

    if (I_RESET) begin
      s_d = '0;
      s_d.beat = loop_ctrl_pkg::RST_BEAT;
      for (int c = 0; c < 2; c++)
        s_d.period[c] = 32'h1;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    s_q <= s_d;
  end

  logic [1:0] mute_q;
  logic [1:0] rec_q;
  logic [1:0] full_q;
  logic [2*AW-1:0] wa_q;
  logic [2*AW-1:0] ra_q;
  always_ff @(posedge I_SYS_CLK) begin
    for (int c = 0; c < 2; c++) begin
      mute_q[c] <= !I_RESET && s_d.ch[c].mode == loop_ctrl_pkg::ST_CLEARING;
      rec_q[c]  <= !I_RESET && s_d.ch[c].mode == loop_ctrl_pkg::ST_RUN;
      full_q[c] <= !I_RESET && s_d.ch[c].mode == loop_ctrl_pkg::ST_FROZEN;
      wa_q[c*AW +: AW] <= (s_d.ch[c].mode == loop_ctrl_pkg::ST_CLEARING) ? s_d.ch[c].clr_addr : s_d.ch[c].wr_ptr;
      ra_q[c*AW +: AW] <= s_d.ch[c].rd_ptr;
    end
  end

  assign PRDATA      = s_q.prdata;
  assign PREADY      = s_q.pready;
  assign PSLVERR     = s_q.pslverr;
  assign O_MUTE      = mute_q;
  assign O_LED_FLASH = s_q.flash;
  assign O_REC_EN    = rec_q;
  assign O_REGEN_FULL = full_q;
  assign O_WR_ADDR   = wa_q;
  assign O_RD_ADDR   = ra_q;

  a_frozen_no_record: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    s_q.ch[0].mode == loop_ctrl_pkg::ST_FROZEN |-> (!O_REC_EN[0] && O_REGEN_FULL[0]))
    else $error("frozen channel still records");
  a_run_no_scroll: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (s_q.ch[0].mode == loop_ctrl_pkg::ST_FROZEN && s_d.ch[0].mode == loop_ctrl_pkg::ST_FROZEN
     && $stable(s_q.ch[0].mode)) or $stable(s_q.ch[0].start_ptr) or
     s_q.ch[0].mode != loop_ctrl_pkg::ST_RUN)
    else $error("start pointer moved outside freeze");
  a_start_in_range: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    s_q.ch[0].start_ptr < DEPTH_A && s_q.ch[0].end_ptr < DEPTH_A)
    else $error("window pointer outside memory");
  a_window_len_kept: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (s_q.ch[0].mode == loop_ctrl_pkg::ST_FROZEN && s_d.ch[0].mode == loop_ctrl_pkg::ST_FROZEN)
    |=> (wrap_add(s_q.ch[0].end_ptr, -$signed({2'b00, s_q.ch[0].start_ptr})) ==
         $past(wrap_add(s_q.ch[0].end_ptr, -$signed({2'b00, s_q.ch[0].start_ptr})))))
    else $error("scroll changed window length");
  a_cv_grant: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (s_q.pan[0].regen_knob != s_q.pan_prev[0].regen_knob) |=>
    s_q.ch[0].cv_window == $past(s_q.pan[0].freeze_btn))
    else $error("cv window ownership wrong");
  a_mode_switch: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (s_q.pan[0].dur_knob != s_q.pan_prev[0].dur_knob) |=>
    s_q.ch[0].continuous == $past(s_q.pan[0].freeze_btn))
    else $error("duration mode not switched");
  a_freeze_capture: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (s_q.ch[0].mode == loop_ctrl_pkg::ST_RUN && s_q.tgl[0]) |=>
    (s_q.ch[0].start_ptr == $past(s_q.ch[0].rd_ptr) && s_q.ch[0].end_ptr == $past(s_q.ch[0].wr_ptr)))
    else $error("freeze did not capture pointers");
  a_write_advance: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (s_q.ch[0].mode == loop_ctrl_pkg::ST_RUN ##1 s_q.ch[0].mode == loop_ctrl_pkg::ST_RUN) |->
    s_q.ch[0].wr_ptr == wrap_add($past(s_q.ch[0].wr_ptr), (AW+2)'(1)))
    else $error("write pointer not circular");
  a_clear_isolated: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (s_q.ch[0].mode == loop_ctrl_pkg::ST_CLEARING && !(s_q.pan[1].freeze_btn && s_q.pan[1].flip_btn)
     && s_q.ch[1].mode != loop_ctrl_pkg::ST_CLEARING) |=> s_q.ch[1].mode != loop_ctrl_pkg::ST_CLEARING)
    else $error("clear spread to other channel");
  a_clear_mute: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    s_q.ch[0].mode == loop_ctrl_pkg::ST_CLEARING |-> O_MUTE[0])
    else $error("clearing channel not muted");

  c_freeze: cover property (@(posedge I_SYS_CLK) s_q.ch[0].mode == loop_ctrl_pkg::ST_FROZEN);
  c_scroll: cover property (@(posedge I_SYS_CLK)
    s_q.ch[0].mode == loop_ctrl_pkg::ST_FROZEN && !$stable(s_q.ch[0].start_ptr));
  c_cont: cover property (@(posedge I_SYS_CLK) s_q.ch[1].continuous);
  c_clear: cover property (@(posedge I_SYS_CLK) s_q.ch[1].mode == loop_ctrl_pkg::ST_CLEARING);

endmodule : loop_ctrl
`default_nettype wire

// [panel_model.sv]
// front panel model: packs button, switch, knob and cv settings into register words
// assumes the register layout of the loop control block, channel select per word
`timescale 1ns/100ps
`default_nettype none
module panel_model;
  // buttons are levels; the toggle bit stands for a release of the freeze button
  function automatic logic [31:0] ctrl_w(input logic ch, input logic frz, input logic flip,
                                         input logic tgl, input logic rng);
    ctrl_w = 32'h0000_0000;
    ctrl_w[loop_ctrl_pkg::CB_FREEZE_BTN] = frz;
    ctrl_w[loop_ctrl_pkg::CB_FLIP_BTN]   = flip;
    ctrl_w[loop_ctrl_pkg::CB_FREEZE_TGL] = tgl;
    ctrl_w[loop_ctrl_pkg::CB_RANGE_UP]   = rng;
    ctrl_w[loop_ctrl_pkg::CB_CHAN]       = ch;
  endfunction : ctrl_w
  // both knobs (or both cv inputs) travel together, so the untouched one is resent unchanged
  function automatic logic [31:0] pair_w(input logic ch, input logic [11:0] regen, input logic [11:0] dur);
    pair_w = {ch, 3'h0, dur, 4'h0, regen};
  endfunction : pair_w
endmodule : panel_model
`default_nettype wire

// [loop_window_time_mode_ctrl_tb_top.sv]
// self-checking bench for the loop control block, driven over apb
// assumes short memory and clear-hold parameters so the run stays brief
`timescale 1ns/100ps
`default_nettype none
module loop_window_time_mode_ctrl_tb_top;
  // deep enough that no period in the scenarios is clipped to the memory depth
  localparam int DEP = 4096;
  localparam int CLR = 50;
  localparam int BT  = 32;
  logic        I_SYS_CLK = 1'b0;
  logic        I_RESET   = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdv;
  logic        pready, pslverr, errv;
  logic [1:0]  mute, flash, rec_en, regen_full;
  logic [47:0] wr_addr, rd_addr;
  logic [31:0] s0, p0, p1, q0, q1;
  int          bad_count = 0;
  int          n_tests   = 0;
  always #5 I_SYS_CLK = ~I_SYS_CLK;
  panel_model i_panel_model ();
  loop_ctrl #(.DEPTH(DEP), .CLEAR_CYC(CLR)) i_loop_ctrl (
    .I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .O_MUTE(mute), .O_LED_FLASH(flash), .O_REC_EN(rec_en), .O_REGEN_FULL(regen_full),
    .O_WR_ADDR(wr_addr), .O_RD_ADDR(rd_addr));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic chkb(input string nm, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", nm, exp, got);
    end
  endtask : chkb
  // request held until pready is seen at a rising edge; data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge I_SYS_CLK);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge I_SYS_CLK);
    penable <= 1'b1;
    do begin
      @(posedge I_SYS_CLK);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 40) chkb("pready", 1'b1, 1'b0);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic knobs(input logic [11:0] rg, input logic [11:0] du);
    wr(loop_ctrl_pkg::OFF_KNOBS, i_panel_model.pair_w(1'b0, rg, du));
  endtask : knobs
  task automatic ctrl(input logic frz, input logic flip, input logic tgl, input logic rng);
    wr(loop_ctrl_pkg::OFF_CTRL, i_panel_model.ctrl_w(1'b0, frz, flip, tgl, rng));
  endtask : ctrl
  task automatic dcv(input logic [11:0] c);
    wr(loop_ctrl_pkg::OFF_CV, i_panel_model.pair_w(1'b0, 12'h000, c));
    rd(loop_ctrl_pkg::OFF_PERIOD);
  endtask : dcv
  initial begin
    #300000;
    chkb("watchdog", 1'b1, 1'b0);
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge I_SYS_CLK);
    I_RESET <= 1'b0;
    rd(loop_ctrl_pkg::OFF_BEAT);
    chk("beat reset", loop_ctrl_pkg::RST_BEAT, rdv);
    rd(loop_ctrl_pkg::OFF_STAT);
    chk("stat reset", 32'h0000_0000, rdv);
    chk("rec_en", 32'h0000_0003, {30'h0, rec_en});
    rd(8'h20);
    chkb("rd 20 err", 1'b1, errv);
    wr(8'h24, 32'h0000_0001);
    chkb("wr 24 err", 1'b1, errv);
    rd(loop_ctrl_pkg::OFF_PERIOD);
    chkb("rd 1c err", 1'b0, errv);
    wr(loop_ctrl_pkg::OFF_BEAT, BT);
    rd(loop_ctrl_pkg::OFF_BEAT);
    chk("beat rw", BT, rdv);
    // write pointers advance one sample a clock and stay inside the memory
    @(posedge I_SYS_CLK);
    s0 = wr_addr[23:0];
    repeat (70) @(posedge I_SYS_CLK);
    chk("wr adv ch0", (s0 + 70) % DEP, wr_addr[23:0]);
    chkb("wr ch1 range", 1'b1, wr_addr[47:24] < DEP);
    knobs(12'hfff, 12'h800);
    ctrl(1'b0, 1'b0, 1'b1, 1'b0);
    ctrl(1'b0, 1'b0, 1'b0, 1'b0);
    chk("regen_full", 32'h0000_0001, {30'h0, regen_full});
    chk("rec_en frz", 32'h0000_0002, {30'h0, rec_en});
    rd(loop_ctrl_pkg::OFF_START);
    s0 = rdv;
    rd(loop_ctrl_pkg::OFF_PERIOD);
    p0 = rdv;
    ctrl(1'b1, 1'b0, 1'b0, 1'b0);
    knobs(12'h7ff, 12'h800);
    rd(loop_ctrl_pkg::OFF_START);
    chk("start scrolled", (s0 + 64 * DEP - (longint'(p0) * 2048) / 4096) % DEP, rdv);
    s0 = rdv;
    rd(loop_ctrl_pkg::OFF_STAT);
    chk("stat cv", 32'h0000_0005, {28'h0, rdv[3:0]});
    ctrl(1'b0, 1'b0, 1'b0, 1'b0);
    knobs(12'hfff, 12'h800);
    rd(loop_ctrl_pkg::OFF_START);
    chk("start still", s0, rdv);
    rd(loop_ctrl_pkg::OFF_STAT);
    chkb("cv dropped", 1'b0, rdv[2]);
    ctrl(1'b1, 1'b0, 1'b0, 1'b0);
    knobs(12'hfff, 12'h900);
    rd(loop_ctrl_pkg::OFF_STAT);
    chkb("continuous", 1'b1, rdv[3]);
    dcv(12'h000);
    p0 = rdv;
    // eight codes are needed for one sample of period change at this beat
    knobs(12'hfff, 12'h908);
    rd(loop_ctrl_pkg::OFF_PERIOD);
    chkb("no snap", 1'b1, rdv != p0);
    knobs(12'hfff, 12'h900);
    dcv(12'd683);
    chkb("cv halves", 1'b1, rdv * 2 + 1 >= p0 && rdv * 2 <= p0 + 1);
    ctrl(1'b0, 1'b0, 1'b0, 1'b0);
    knobs(12'hfff, 12'ha00);
    rd(loop_ctrl_pkg::OFF_STAT);
    chkb("snapped", 1'b0, rdv[3]);
    dcv(12'h000);
    q0 = rdv;
    chk("snap grid", 32'h0000_0000, q0 % (BT / 16));
    knobs(12'hfff, 12'ha01);
    rd(loop_ctrl_pkg::OFF_PERIOD);
    chk("snap same", q0, rdv);
    dcv(12'd683);
    q1 = rdv;
    chkb("cv lengthens", 1'b1, q1 > q0);
    ctrl(1'b0, 1'b0, 1'b0, 1'b1);
    rd(loop_ctrl_pkg::OFF_PERIOD);
    chk("range up", q1 + loop_ctrl_pkg::RANGE_BARS * loop_ctrl_pkg::BAR_BEATS * BT, rdv);
    ctrl(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (CLR - 15) @(posedge I_SYS_CLK);
    chk("mute early", 32'h0000_0000, {30'h0, mute});
    repeat (40) @(posedge I_SYS_CLK);
    chk("mute", 32'h0000_0001, {30'h0, mute});
    chkb("ch1 records", 1'b1, rec_en[1]);
    rd(loop_ctrl_pkg::OFF_STAT);
    chk("mode clear", 32'h0000_0002, {30'h0, rdv[1:0]});
    ctrl(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (3 * DEP) @(posedge I_SYS_CLK);
    chk("mute over", 32'h0000_0000, {30'h0, mute});
    tally_and_finish();
  end
endmodule : loop_window_time_mode_ctrl_tb_top
`default_nettype wire
